/* File: design/adc_seq_pkg.sv */
package adc_seq_pkg;
  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_CNT_SLOT10 = 14'h2100;
  localparam logic [13:0] IDX_SLOT8_9 = 14'h2101;
  localparam logic [13:0] IDX_SLOT6_7 = 14'h2102;
  localparam logic [13:0] IDX_SLOT4_5 = 14'h2103;
  localparam logic [13:0] IDX_SLOT2_3 = 14'h2104;
  localparam logic [13:0] IDX_SLOT0_1 = 14'h2105;
  localparam logic [13:0] IDX_EQU_CHOP = 14'h2106;
  localparam logic [13:0] IDX_FILT_DIFF = 14'h210c;
  localparam logic [13:0] IDX_RATE_PLL = 14'h2200;
  localparam logic [13:0] IDX_PREAMP = 14'h2704;
  localparam logic [13:0] IDX_REMOTE = 14'h2709;
  localparam logic [13:0] IDX_STATUS = 14'h2110;
  // Field positions
  localparam int SLOT_CNT_LSB = 4;
  localparam int EQU_LSB = 5;
  localparam int CHOP_LSB = 2;
  localparam int FILT_LSB = 1;
  localparam int DIFF_LSB = 4;
  localparam int RATE_BIT = 5;
  localparam int PLL_FAST_BIT = 4;
  localparam int PREAMP_BIT = 5;
  localparam int REMOTE_LSB = 3;
  // Implemented bits per register; others read zero
  localparam logic [7:0] EQU_CHOP_MASK = 8'hec;
  localparam logic [7:0] FILT_DIFF_MASK = 8'hf6;
  localparam logic [7:0] RATE_PLL_MASK = 8'h30;
  localparam logic [7:0] PREAMP_MASK = 8'h20;
  localparam logic [7:0] REMOTE_MASK = 8'h38;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Encodings
  localparam logic [2:0] EQU_THREE_PHASE = 3'h5;
  localparam logic [3:0] HANDLE_MAX = 4'ha;
  localparam logic [3:0] SLOT_LAST = 4'ha;
  localparam logic [1:0] CHOP_LOW = 2'h1;
  localparam logic [1:0] CHOP_HIGH = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // Slow-clock rate in Hz; frame timing in slow-clock periods
  localparam int SLOW_CLK_HZ = 32768;
  localparam int FRAME_CYC_REMOTE = 13;
  localparam int FRAME_CYC_CT = 15;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE = 2'b01,
    ST_SLOT = 2'b10
  } seq_state_e;
endpackage

/* File: design/frame_sequencer.sv */
`timescale 1ns/1ps
module frame_sequencer
  import adc_seq_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Slow clock pin
  input wire logic slow_clock_32k_in,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Multiplexer, filter and engine
  output logic [3:0] slot_input_select_out,
  output logic [3:0] slot_index_out,
  output logic mux_advance_out,
  output logic filter_start_out,
  output logic engine_start_out,
  output logic chop_phase_out,
  output logic remote_window_out,
  // Static configuration
  output logic [3:0] differential_enable_out,
  output logic [2:0] remote_pair_enable_out,
  output logic neutral_gain_eight_out,
  output logic [2:0] energy_equation_select_out,
  output logic three_phase_sum_out,
  output logic [1:0] filter_length_out
);
  import adc_seq_pkg::*;

  if (ADDR_W < 16)
  begin : g_check
    $error("ADDR_W must be at least 16");
  end

  typedef struct packed {
    logic [2:0] sync;
    logic [5:0][7:0] sel;
    logic [7:0] equ_chop;
    logic [7:0] filt;
    logic [7:0] rate;
    logic [7:0] pre;
    logic [7:0] rmt;
    seq_state_e st;
    logic [3:0] slot;
    logic [4:0] left;
    logic [8:0] frame_cyc;
    logic [8:0] frame_len;
    logic [3:0] slots_lat;
    logic [4:0] slot_len_lat;
    logic [3:0] mux_sel;
    logic mux_adv;
    logic filt_start;
    logic eng_start;
    logic chop;
    logic remote_win;
    logic aw_got;
    logic [13:0] aw_idx;
    logic aw_ok;
    logic w_got;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s cur_r;
  state_s cur_nxt;
  logic tick;
  logic [4:0] slot_len_now;
  logic [1:0] pre_len_now;

  // Slot k lives in register 0x2105 - k/2, low nibble for even k
  function automatic logic [3:0] sel_of(input logic [5:0][7:0] s, input logic [3:0] k);
    logic [3:0] v;
    v = 4'h0;
    if (k <= SLOT_LAST)
      v = k[0] ? s[k[3:1]][7:4] : s[k[3:1]][3:0];
    return v;
  endfunction

  function automatic logic [4:0] slot_len(input logic pf, input logic [1:0] fl, input logic ad);
    logic [4:0] t;
    // Widened before the add, so a length field of three counts four, not zero
    t = 5'((pf ? 5'h1 : 5'h3) * (5'(fl) + 5'h1));
    if (ad)
      t = {t[3:0], 1'b0};
    return t;
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [13:0] i;
    logic hit;
    i = a[15:2];
    case (i)
      IDX_CNT_SLOT10, IDX_SLOT8_9, IDX_SLOT6_7, IDX_SLOT4_5, IDX_SLOT2_3, IDX_SLOT0_1,
      IDX_EQU_CHOP, IDX_FILT_DIFF, IDX_RATE_PLL, IDX_PREAMP, IDX_REMOTE, IDX_STATUS:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit && (a[1:0] == 2'h0) && ((a >> 16) == '0);
  endfunction

  function automatic logic [7:0] read_reg(input state_s c, input logic [13:0] i);
    logic [7:0] v;
    case (i)
      IDX_CNT_SLOT10: v = c.sel[5];
      IDX_SLOT8_9: v = c.sel[4];
      IDX_SLOT6_7: v = c.sel[3];
      IDX_SLOT4_5: v = c.sel[2];
      IDX_SLOT2_3: v = c.sel[1];
      IDX_SLOT0_1: v = c.sel[0];
      IDX_EQU_CHOP: v = c.equ_chop;
      IDX_FILT_DIFF: v = c.filt;
      IDX_RATE_PLL: v = c.rate;
      IDX_PREAMP: v = c.pre;
      IDX_REMOTE: v = c.rmt;
      IDX_STATUS: v = {1'b0, c.remote_win, c.chop, c.st != ST_IDLE, c.slot};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // The third stage only feeds edge detection; the first is metastable
  assign tick = cur_r.sync[1] & ~cur_r.sync[2];
  assign slot_len_now = slot_len(cur_r.rate[PLL_FAST_BIT], cur_r.filt[FILT_LSB +: 2],
                                 cur_r.rate[RATE_BIT]);
  assign pre_len_now = cur_r.rate[PLL_FAST_BIT] ? 2'h1 : 2'h3;

  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.sync = {cur_r.sync[1:0], slow_clock_32k_in};
    cur_nxt.mux_adv = 1'b0;
    cur_nxt.filt_start = 1'b0;
    cur_nxt.eng_start = 1'b0;

    // Register bus: address and data may arrive in either order
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      cur_nxt.aw_got = 1'b1;
      cur_nxt.aw_idx = s_axi_awaddr_in[15:2];
      cur_nxt.aw_ok = addr_ok(s_axi_awaddr_in);
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      cur_nxt.w_got = 1'b1;
      cur_nxt.wdata = s_axi_wdata_in[7:0];
      cur_nxt.wstb = s_axi_wstrb_in[0];
    end
    if (cur_r.aw_got && cur_r.w_got)
    begin
      cur_nxt.aw_got = 1'b0;
      cur_nxt.w_got = 1'b0;
      cur_nxt.bvalid = 1'b1;
      cur_nxt.bresp = cur_r.aw_ok ? AXI_OKAY : AXI_SLVERR;
      if (cur_r.aw_ok && cur_r.wstb)
      begin
        case (cur_r.aw_idx)
          IDX_CNT_SLOT10: cur_nxt.sel[5] = cur_r.wdata;
          IDX_SLOT8_9: cur_nxt.sel[4] = cur_r.wdata;
          IDX_SLOT6_7: cur_nxt.sel[3] = cur_r.wdata;
          IDX_SLOT4_5: cur_nxt.sel[2] = cur_r.wdata;
          IDX_SLOT2_3: cur_nxt.sel[1] = cur_r.wdata;
          IDX_SLOT0_1: cur_nxt.sel[0] = cur_r.wdata;
          IDX_EQU_CHOP: cur_nxt.equ_chop = cur_r.wdata & EQU_CHOP_MASK;
          IDX_FILT_DIFF: cur_nxt.filt = cur_r.wdata & FILT_DIFF_MASK;
          IDX_RATE_PLL: cur_nxt.rate = cur_r.wdata & RATE_PLL_MASK;
          IDX_PREAMP: cur_nxt.pre = cur_r.wdata & PREAMP_MASK;
          IDX_REMOTE: cur_nxt.rmt = cur_r.wdata & REMOTE_MASK;
          // Status is read-only: a write there is accepted and dropped
          default: cur_nxt.bresp = AXI_OKAY;
        endcase
      end
    end
    else if (s_axi_bready_in && cur_r.bvalid)
      cur_nxt.bvalid = 1'b0;
    if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      cur_nxt.rvalid = 1'b1;
      cur_nxt.rdata = read_reg(cur_r, s_axi_araddr_in[15:2]);
      cur_nxt.rresp = addr_ok(s_axi_araddr_in) ? AXI_OKAY : AXI_SLVERR;
      if (!addr_ok(s_axi_araddr_in))
        cur_nxt.rdata = 8'h00;
    end
    else if (s_axi_rready_in && cur_r.rvalid)
      cur_nxt.rvalid = 1'b0;

    // Forced chop levels follow the field at once
    if (cur_r.equ_chop[CHOP_LSB +: 2] == CHOP_LOW)
      cur_nxt.chop = 1'b0;
    else if (cur_r.equ_chop[CHOP_LSB +: 2] == CHOP_HIGH)
      cur_nxt.chop = 1'b1;

    // Sequencer: moves only on slow-clock rising edges
    if (tick)
    begin
      cur_nxt.frame_cyc = 9'(cur_r.frame_cyc + 9'h1);
      case (cur_r.st)
        ST_PRE:
        begin
          if (cur_r.left == 5'h0)
          begin
            cur_nxt.st = ST_SLOT;
            cur_nxt.slot = 4'h0;
            cur_nxt.left = 5'(cur_r.slot_len_lat - 5'h1);
            cur_nxt.mux_sel = sel_of(cur_r.sel, 4'h0);
            cur_nxt.mux_adv = 1'b1;
            cur_nxt.filt_start = 1'b1;
          end
          else
            cur_nxt.left = 5'(cur_r.left - 5'h1);
        end
        ST_SLOT:
        begin
          if (cur_r.left != 5'h0)
            cur_nxt.left = 5'(cur_r.left - 5'h1);
          else if (cur_r.slot != 4'(cur_r.slots_lat - 4'h1))
          begin
            cur_nxt.slot = 4'(cur_r.slot + 4'h1);
            cur_nxt.left = 5'(cur_r.slot_len_lat - 5'h1);
            cur_nxt.mux_sel = sel_of(cur_r.sel, 4'(cur_r.slot + 4'h1));
            cur_nxt.mux_adv = 1'b1;
            cur_nxt.filt_start = 1'b1;
          end
          else
            cur_nxt.st = ST_IDLE;
        end
        default:
          cur_nxt.st = ST_IDLE;
      endcase
      // Frame boundary: slot count and lengths are latched here, so later writes to them wait a frame
      if (cur_nxt.st == ST_IDLE)
      begin
        cur_nxt.slot = 4'h0;
        cur_nxt.frame_cyc = 9'h0;
        if (cur_r.sel[5][SLOT_CNT_LSB +: 4] != 4'h0)
        begin
          cur_nxt.st = ST_PRE;
          cur_nxt.slots_lat = cur_r.sel[5][SLOT_CNT_LSB +: 4];
          cur_nxt.slot_len_lat = slot_len_now;
          cur_nxt.left = 5'(pre_len_now - 2'h1);
          cur_nxt.frame_len = 9'(pre_len_now) +
                              9'(slot_len_now) * 9'(cur_r.sel[5][SLOT_CNT_LSB +: 4]);
          cur_nxt.eng_start = 1'b1;
          if (cur_r.equ_chop[CHOP_LSB +: 2] != CHOP_LOW &&
              cur_r.equ_chop[CHOP_LSB +: 2] != CHOP_HIGH)
            cur_nxt.chop = ~cur_r.chop;
        end
      end
      // Remote pairs are sampled over the frame's latter half
      cur_nxt.remote_win = (|cur_r.rmt) && (cur_nxt.st != ST_IDLE) &&
                           ({cur_nxt.frame_cyc, 1'b0} >= {1'b0, cur_nxt.frame_len});
    end
    if (cur_r.st == ST_IDLE && !tick)
      cur_nxt.remote_win = 1'b0;
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      cur_r <= '0;
    else
      cur_r <= cur_nxt;
  end

  assign s_axi_awready_out = ~cur_r.aw_got & ~cur_r.bvalid;
  assign s_axi_wready_out = ~cur_r.w_got & ~cur_r.bvalid;
  assign s_axi_bvalid_out = cur_r.bvalid;
  assign s_axi_bresp_out = cur_r.bresp;
  assign s_axi_arready_out = ~cur_r.rvalid;
  assign s_axi_rvalid_out = cur_r.rvalid;
  assign s_axi_rdata_out = {24'h0, cur_r.rdata};
  assign s_axi_rresp_out = cur_r.rresp;

  assign slot_input_select_out = cur_r.mux_sel;
  assign slot_index_out = cur_r.slot;
  assign mux_advance_out = cur_r.mux_adv;
  assign filter_start_out = cur_r.filt_start;
  assign engine_start_out = cur_r.eng_start;
  assign chop_phase_out = cur_r.chop;
  assign remote_window_out = cur_r.remote_win;
  assign differential_enable_out = cur_r.filt[DIFF_LSB +: 4];
  assign remote_pair_enable_out = cur_r.rmt[REMOTE_LSB +: 3];
  assign neutral_gain_eight_out = cur_r.pre[PREAMP_BIT];
  assign energy_equation_select_out = cur_r.equ_chop[EQU_LSB +: 3];
  assign three_phase_sum_out = cur_r.equ_chop[EQU_LSB +: 3] == EQU_THREE_PHASE;
  assign filter_length_out = cur_r.filt[FILT_LSB +: 2];

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);

  sequence s_both_taken;
    cur_r.aw_got && cur_r.w_got;
  endsequence
  sequence s_answer;
    s_axi_bvalid_out && s_axi_bresp_out == (cur_r.aw_ok ? AXI_OKAY : AXI_SLVERR);
  endsequence
  sequence s_launch;
    engine_start_out ##1 (!engine_start_out)[*8];
  endsequence

  a_idle_quiet: assert property (cur_r.st == ST_IDLE |-> !mux_advance_out && !engine_start_out)
    else $error("activity while idle");
  a_state_on_edge: assert property ((cur_r.st != $past(cur_r.st)) &&
                                    !$past(srst_in) |-> $past(tick))
    else $error("state changed off slow edge");
  a_adv_filter: assert property (mux_advance_out |-> filter_start_out && cur_r.st == ST_SLOT)
    else $error("advance without filter start");
  a_one_launch: assert property (engine_start_out |-> s_launch)
    else $error("engine launched twice");
  a_slot_select: assert property (mux_advance_out && $stable(cur_r.sel)
                                  |-> slot_input_select_out == sel_of(cur_r.sel, cur_r.slot))
    else $error("slot select mismatch");
  a_frame_length: assert property (engine_start_out && $past(cur_r.st) != ST_IDLE
                                   |-> $past(cur_r.frame_cyc) == 9'($past(cur_r.frame_len) - 9'h1))
    else $error("frame length wrong");
  a_slot_length: assert property (mux_advance_out |-> cur_r.left == 5'(cur_r.slot_len_lat - 5'h1))
    else $error("slot length wrong");
  a_remote_only: assert property (remote_window_out |-> (|remote_pair_enable_out))
    else $error("remote window without remote pair");
  a_write_answer: assert property (s_both_taken |=> s_answer)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered");
  a_latch_count: assert property (engine_start_out |-> cur_r.slots_lat != 4'h0 &&
                                  cur_r.slots_lat == $past(cur_r.sel[5][7:4]))
    else $error("slot count not latched");

  sequence s_forced_high;
    cur_r.equ_chop[CHOP_LSB +: 2] == CHOP_HIGH;
  endsequence
  // Reset guards stop a mid-run reset from reading as an off-edge change
  a_chop_high: assert property (s_forced_high |=> chop_phase_out)
    else $error("chop not forced high");
  a_chop_low: assert property (cur_r.equ_chop[CHOP_LSB +: 2] == CHOP_LOW
                               |=> !chop_phase_out)
    else $error("chop not forced low");
  a_filter_pair: assert property (filter_start_out |-> mux_advance_out)
    else $error("filter start without advance");
  a_engine_pre: assert property (engine_start_out |-> cur_r.st == ST_PRE)
    else $error("engine launch outside frame start");
  a_window_running: assert property (remote_window_out |-> cur_r.st != ST_IDLE)
    else $error("remote window while halted");
  a_slot_bound: assert property (cur_r.st == ST_SLOT |-> cur_r.slot < cur_r.slots_lat)
    else $error("slot beyond latched count");
  a_slot_on_tick: assert property (!$past(tick) && !$past(srst_in)
                                   |-> $stable(cur_r.slot))
    else $error("slot moved off slow edge");
  a_select_hold: assert property (!mux_advance_out && !$past(srst_in)
                                  |-> $stable(slot_input_select_out))
    else $error("select changed without advance");
endmodule

/* File: test/far_side_model.sv */
`timescale 1ns/1ps
module far_side_model
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Slow clock toward the sequencer
  output logic slow_clock_32k_out,
  // Sequencer strobes
  input wire logic mux_advance_in,
  input wire logic filter_start_in,
  input wire logic engine_start_in,
  input wire logic remote_window_in,
  input wire logic [3:0] slot_index_in,
  input wire logic [3:0] slot_select_in,
  // Figures of the last finished frame
  output logic [15:0] frame_count_out,
  output logic [15:0] frame_ticks_out,
  output logic [7:0] frame_adv_out,
  output logic frame_rwin_out,
  output logic [10:0][3:0] sel_log_out
);
  // Slow clock sped up to 20 fast cycles, so long frames stay cheap in run time
  localparam int HALF = 10;
  int div = 0;
  int ticks = 0;
  int adv = 0;
  logic rwin = 1'b0;
  initial slow_clock_32k_out = 1'b0;
  always @(posedge clock_in)
  begin
    div <= (div == HALF - 1) ? 0 : div + 1;
    if (div == HALF - 1)
    begin
      slow_clock_32k_out <= ~slow_clock_32k_out;
      if (!slow_clock_32k_out)
        ticks <= ticks + 1;
    end
    if (mux_advance_in && filter_start_in)
    begin
      adv <= adv + 1;
      if (slot_index_in < 4'hb)
        sel_log_out[slot_index_in] <= slot_select_in;
    end
    if (remote_window_in)
      rwin <= 1'b1;
    if (engine_start_in)
    begin
      frame_count_out <= frame_count_out + 16'h1;
      frame_ticks_out <= 16'(ticks);
      frame_adv_out <= 8'(adv);
      frame_rwin_out <= rwin;
      ticks <= 0;
      adv <= 0;
      rwin <= 1'b0;
    end
    if (srst_in)
    begin
      frame_count_out <= 16'h0;
      adv <= 0;
      rwin <= 1'b0;
    end
  end
endmodule

/* File: test/tb_adc_mux_frame_sequencer.sv */
`timescale 1ns/1ps
module tb_adc_mux_frame_sequencer;
  import adc_seq_pkg::*;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic slow_clk;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, flt;
  logic [3:0] sel, sidx, dif_o;
  logic adv, fst, est, chop, rwin, gain, sum;
  logic [2:0] rmt_o, equ;
  logic [15:0] fc, ft;
  logic [7:0] fa;
  logic fr;
  logic [10:0][3:0] sl;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] rnd = 32'h202ec91f;
  logic [13:0] ridx [11] = '{IDX_CNT_SLOT10, IDX_SLOT8_9, IDX_SLOT6_7, IDX_SLOT4_5, IDX_SLOT2_3,
    IDX_SLOT0_1, IDX_EQU_CHOP, IDX_FILT_DIFF, IDX_RATE_PLL, IDX_PREAMP, IDX_REMOTE};
  logic [7:0] rmask [11] = '{8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, EQU_CHOP_MASK,
    FILT_DIFF_MASK, RATE_PLL_MASK, PREAMP_MASK, REMOTE_MASK};
  always #12.5 clock_in = ~clock_in;
  frame_sequencer #(.ADDR_W(16)) dut (.clock_in(clock_in), .srst_in(srst_in),
    .slow_clock_32k_in(slow_clk), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .slot_input_select_out(sel), .slot_index_out(sidx), .mux_advance_out(adv),
    .filter_start_out(fst), .engine_start_out(est), .chop_phase_out(chop),
    .remote_window_out(rwin), .differential_enable_out(dif_o),
    .remote_pair_enable_out(rmt_o), .neutral_gain_eight_out(gain),
    .energy_equation_select_out(equ), .three_phase_sum_out(sum), .filter_length_out(flt));
  far_side_model partner (.clock_in(clock_in), .srst_in(srst_in), .slow_clock_32k_out(slow_clk),
    .mux_advance_in(adv), .filter_start_in(fst), .engine_start_in(est), .remote_window_in(rwin),
    .slot_index_in(sidx), .slot_select_in(sel), .frame_count_out(fc), .frame_ticks_out(ft),
    .frame_adv_out(fa), .frame_rwin_out(fr), .sel_log_out(sl));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] flen(input logic pf, input logic [1:0] fir, input logic rate,
      input logic [3:0] cnt);
    int p = 3 - 2 * int'(pf);
    return 32'(p + p * (int'(fir) + 1) * (int'(rate) + 1) * int'(cnt));
  endfunction
  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic fail_wait;
    n_mismatch++;
    $display("Error wait bound expected answer seen none");
    stop_test();
  endtask
  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    int n = 0;
    @(posedge clock_in);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock_in);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    if (n >= 200)
      fail_wait();
    check("bresp", 32'(AXI_OKAY), 32'(bresp));
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [13:0] i, input logic [1:0] er, output logic [31:0] d);
    int n = 0;
    @(posedge clock_in);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock_in);
      if (arvalid && arready)
        arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    if (n >= 200)
      fail_wait();
    d = rdata;
    check("rresp", 32'(er), 32'(rresp));
    rready <= 1'b0;
  endtask
  // Slot count goes to zero first so no new frame launches until reconfiguring is done
  task automatic run_cfg(input logic [10:0][3:0] s, input logic [3:0] cnt, input logic pf,
      input logic [1:0] fir, input logic rate, input logic [3:0] dif, input logic [2:0] rm,
      input logic pre);
    int t = 0;
    int f0;
    wr(IDX_CNT_SLOT10, 8'h00);
    for (int k = 0; k < 5; k++)
      wr(IDX_SLOT0_1 - 14'(k), {s[2*k+1], s[2*k]});
    wr(IDX_RATE_PLL, {2'h0, rate, pf, 4'h0});
    wr(IDX_FILT_DIFF, {dif, 1'b0, fir, 1'b0});
    wr(IDX_REMOTE, {2'h0, rm, 3'h0});
    wr(IDX_PREAMP, {2'h0, pre, 5'h0});
    wr(IDX_EQU_CHOP, {EQU_THREE_PHASE, 5'h0});
    wr(IDX_CNT_SLOT10, {cnt, s[10]});
    f0 = fc;
    while (fc - f0 < 3 && t < 40000)
    begin
      @(posedge clock_in);
      t++;
    end
    if (t >= 40000)
      fail_wait();
    check("frame ticks", flen(pf, fir, rate, cnt), 32'(ft));
    check("slot advances", 32'(cnt), 32'(fa));
    check("remote window", 32'(|rm), 32'(fr));
    for (int k = 0; k < cnt; k++)
      check("slot select", 32'(s[k]), 32'(sl[k]));
    check("diff enables", 32'(dif), 32'(dif_o));
    check("remote enables", 32'(rm), 32'(rmt_o));
    check("neutral gain", 32'(pre), 32'(gain));
    check("filter length", 32'(fir), 32'(flt));
  endtask
  initial
  begin
    logic [31:0] d;
    logic [10:0][3:0] s;
    int f0;
    repeat (8) @(posedge clock_in);
    srst_in <= 1'b0;
    for (int k = 0; k < 11; k++)
    begin
      rd(ridx[k], AXI_OKAY, d);
      check("reset value", 32'h0, d);
      rnd = lfsr(rnd);
      wr(ridx[k], rnd[7:0] & (k == 0 ? 8'h0f : 8'hff));
      rd(ridx[k], AXI_OKAY, d);
      check("read back", 32'(rnd[7:0] & rmask[k]), d);
    end
    rd(14'h2111, AXI_SLVERR, d);
    check("unmapped read", 32'h0, d);
    for (int e = 0; e < 8; e++)
    begin
      wr(IDX_EQU_CHOP, {3'(e), 5'h0});
      repeat (2) @(posedge clock_in);
      check("equation", 32'(e), 32'(equ));
      check("three phase", 32'(e == 5), 32'(sum));
    end
    wr(IDX_EQU_CHOP, {3'h0, CHOP_HIGH, 2'h0});
    repeat (2) @(posedge clock_in);
    check("chop forced high", 32'h1, 32'(chop));
    rd(IDX_STATUS, AXI_OKAY, d);
    check("status", 32'h20, d);
    wr(IDX_EQU_CHOP, {3'h0, CHOP_LOW, 2'h0});
    repeat (2) @(posedge clock_in);
    check("chop forced low", 32'h0, 32'(chop));
    run_cfg(44'h00000a69482, 4'h7, 1'b1, 2'h1, 1'b0, 4'hf, 3'h0, 1'b0);
    check("ct frame", 32'(FRAME_CYC_CT), 32'(ft));
    run_cfg(44'h00000a98310, 4'h6, 1'b1, 2'h1, 1'b0, 4'h1, 3'h7, 1'b1);
    check("remote frame", 32'(FRAME_CYC_REMOTE), 32'(ft));
    repeat (2)
    begin
      rnd = lfsr(rnd);
      for (int k = 0; k < 11; k++)
        s[k] = 4'((k + int'(rnd[15:12])) % (int'(HANDLE_MAX) + 1));
      run_cfg(s, 4'(1 + rnd[7:4] % 11), rnd[0], rnd[2:1], rnd[3], rnd[11:8], rnd[18:16],
        rnd[19]);
    end
    wr(IDX_CNT_SLOT10, 8'h00);
    // A launch decided just before the write may still be counted
    repeat (4) @(posedge clock_in);
    f0 = fc;
    // Longer than the longest frame the test sets up, so a frame boundary surely falls inside
    repeat (6000) @(posedge clock_in);
    check("halted frames", 32'(f0), 32'(fc));
    stop_test();
  end
endmodule
